/* process_data_link_mapper.sv */
module process_data_link_mapper #(
  parameter int unsigned BUS_CYCLE_CYCLES = pd_link_pkg::BUS_CYCLE_CYC
) (
  // Clock and reset
  input  wire logic          core_clk_in,
  input  wire logic          resetn_in,
  // Start-up configuration
  input  wire logic [3:0]    module_firmware_select_in,
  input  wire logic [6:0]    link_node_address_in,
  input  wire logic [1:0]    link_sync_settings_in,
  input  wire logic [6:0]    link_max_node_count_in,
  // Interface assignment and option slot
  input  wire logic [7:0]    interface_hw_assignment_in,
  input  wire logic          option_present_in,
  // Current-control cycle pulse
  input  wire logic          ctrl_cycle_in,
  // Send data
  input  wire logic [255:0]  send_word_source_in,
  input  wire logic [79:0]   send_slot_table_in,
  // Receive mapping
  input  wire logic [111:0]  receive_source_address_table_in,
  input  wire logic [79:0]   receive_word_index_table_in,
  // Telegram received from the link
  input  wire logic          rx_valid_in,
  input  wire logic [6:0]    rx_src_in,
  input  wire logic [3:0]    rx_pos_in,
  input  wire logic [15:0]   rx_data_in,
  // Telegram sent to the link
  output logic               tx_valid_out,
  output logic [15:0]        tx_data_out,
  output logic               tx_first_out,
  input  wire logic          tx_ready_in,
  // Receive results
  output logic [255:0]       receive_word_array_out,
  output logic [479:0]       receive_dword_array_out,
  // Status
  output logic               link_active_out,
  output logic               sync_master_out,
  output logic               bus_cycle_out,
  output logic               sender_missing_alarm_out,
  output logic [6:0]         sender_missing_node_out,
  output logic               setpoint_timeout_fault_out,
  input  wire logic          fault_ack_in,
  output logic [1:0]         cyclic_interface_one_out,
  output logic [1:0]         cyclic_interface_two_out,
  output logic [15:0]        option_slot_ident_out
);

  localparam int unsigned TW = pd_link_pkg::TEL_WORDS;
  localparam int unsigned NM = pd_link_pkg::MAX_NODES;

  function automatic logic [6:0] next_missing(input logic [NM:0] mask,
                                              input logic [6:0] last);
    logic [6:0] found;
    logic       hit;
    int unsigned k;
    found = 7'h00;
    hit   = 1'b0;
    for (int unsigned i = 1; i <= NM; i++) begin
      k = ((int'(last) + i - 1) % NM) + 1;
      if (!hit && mask[k]) begin
        found = 7'(k);
        hit   = 1'b1;
      end
    end
    return found;
  endfunction : next_missing

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture and pin synchronisers

  logic       cfg_taken_ff;
  logic       cfg_en_ff;
  logic [6:0] cfg_addr_ff;
  logic       cfg_sync_ff;
  logic [6:0] cfg_nodes_ff;
  logic       opt_meta_ff;
  logic       opt_sync_ff;
  logic       nxt_cfg_en;
  logic [6:0] nxt_cfg_nodes;

  always_comb begin
    nxt_cfg_en = (module_firmware_select_in == pd_link_pkg::FW_SEL_LINK) &&
                 (link_node_address_in != pd_link_pkg::NODE_OFF);
    nxt_cfg_nodes = link_max_node_count_in;
    if (link_sync_settings_in[pd_link_pkg::SYNC_BIT] &&
        link_max_node_count_in > 7'(pd_link_pkg::MAX_NODES_SYNC)) begin
      nxt_cfg_nodes = 7'(pd_link_pkg::MAX_NODES_SYNC);
    end else if (link_max_node_count_in > 7'(NM)) begin
      nxt_cfg_nodes = 7'(NM);
    end
  end

  // Settings are taken once after reset release only
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      cfg_taken_ff <= 1'b0;
      cfg_en_ff    <= 1'b0;
      cfg_addr_ff  <= 7'h00;
      cfg_sync_ff  <= 1'b0;
      cfg_nodes_ff <= 7'h00;
      opt_meta_ff  <= 1'b0;
      opt_sync_ff  <= 1'b0;
    end else begin
      opt_meta_ff <= option_present_in;
      opt_sync_ff <= opt_meta_ff;
      if (!cfg_taken_ff) begin
        cfg_taken_ff <= 1'b1;
        cfg_en_ff    <= nxt_cfg_en;
        cfg_addr_ff  <= link_node_address_in;
        cfg_sync_ff  <= link_sync_settings_in[pd_link_pkg::SYNC_BIT];
        cfg_nodes_ff <= nxt_cfg_nodes;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle timing

  logic [31:0] div_ff;
  logic [31:0] nxt_div;
  logic        tick_ff;
  logic        nxt_tick;

  always_comb begin
    nxt_div  = div_ff;
    nxt_tick = 1'b0;
    if (!cfg_en_ff) begin
      nxt_div = 32'h0;
    end else if (cfg_sync_ff) begin
      nxt_tick = ctrl_cycle_in;
    end else if (div_ff >= 32'(BUS_CYCLE_CYCLES - 1)) begin
      nxt_div  = 32'h0;
      nxt_tick = 1'b1;
    end else begin
      nxt_div = div_ff + 32'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      div_ff  <= 32'h0;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Telegram transmit

  logic       tx_busy_ff;
  logic       nxt_tx_busy;
  logic [3:0] tx_pos_ff;
  logic [3:0] nxt_tx_pos;
  logic       buf_in_ready;
  logic       buf_in_valid;
  logic [4:0] cur_slot;
  logic [16:0] buf_in_data;

  always_comb begin
    cur_slot     = send_slot_table_in[5*tx_pos_ff +: 5];
    buf_in_valid = tx_busy_ff;
    buf_in_data[16] = (tx_pos_ff == 4'h0);
    buf_in_data[15:0] = 16'h0000;
    if (cur_slot != 5'h00) begin
      buf_in_data[15:0] = send_word_source_in[16*(cur_slot-5'h01) +: 16];
    end
    nxt_tx_busy = tx_busy_ff;
    nxt_tx_pos  = tx_pos_ff;
    if (tx_busy_ff && buf_in_ready) begin
      nxt_tx_pos = tx_pos_ff + 4'h1;
      if (tx_pos_ff == 4'(TW - 1)) begin
        nxt_tx_busy = 1'b0;
      end
    end else if (!tx_busy_ff && tick_ff && cfg_en_ff) begin
      nxt_tx_busy = 1'b1;
      nxt_tx_pos  = 4'h0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      tx_busy_ff <= 1'b0;
      tx_pos_ff  <= 4'h0;
    end else begin
      tx_busy_ff <= nxt_tx_busy;
      tx_pos_ff  <= nxt_tx_pos;
    end
  end

  logic [16:0] buf_out_data;

  pd_skid_buffer #(
    .WIDTH(17)
  ) u_tx_buf (
    .core_clk_in  (core_clk_in),
    .resetn_in    (resetn_in),
    .in_valid_in  (buf_in_valid),
    .in_data_in   (buf_in_data),
    .in_ready_out (buf_in_ready),
    .out_valid_out(tx_valid_out),
    .out_data_out (buf_out_data),
    .out_ready_in (tx_ready_in)
  );

  assign tx_data_out  = buf_out_data[15:0];
  assign tx_first_out = buf_out_data[16];

  ////////////////////////////////////////////////////////////////////////////
  // Receive mapping

  logic [255:0] shadow_ff;
  logic [255:0] nxt_shadow;
  logic [255:0] rx_word_ff;
  logic [255:0] nxt_rx_word;
  logic [479:0] rx_dword_ff;
  logic [479:0] nxt_rx_dword;

  always_comb begin
    logic [6:0] src;
    logic [4:0] idx;
    src = 7'h00;
    idx = 5'h00;
    nxt_shadow = shadow_ff;
    for (int unsigned s = 0; s < TW; s++) begin
      src = receive_source_address_table_in[7*s +: 7];
      idx = receive_word_index_table_in[5*s +: 5];
      if (rx_valid_in && cfg_en_ff && src != pd_link_pkg::NODE_OFF &&
          idx != 5'h00 && src != cfg_addr_ff &&
          rx_src_in == src &&
          {1'b0, rx_pos_in} == idx - 5'h01) begin
        nxt_shadow[16*s +: 16] = rx_data_in;
      end
    end
    nxt_rx_word  = rx_word_ff;
    nxt_rx_dword = rx_dword_ff;
    if (tick_ff) begin
      nxt_rx_word = shadow_ff;
      for (int unsigned s = 0; s < TW - 1; s++) begin
        nxt_rx_dword[32*s +: 32] = {shadow_ff[16*s +: 16],
                                    shadow_ff[16*(s+1) +: 16]};
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      shadow_ff   <= '0;
      rx_word_ff  <= '0;
      rx_dword_ff <= '0;
    end else begin
      shadow_ff   <= nxt_shadow;
      rx_word_ff  <= nxt_rx_word;
      rx_dword_ff <= nxt_rx_dword;
    end
  end

  assign receive_word_array_out  = rx_word_ff;
  assign receive_dword_array_out = rx_dword_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sender supervision

  pd_link_pkg::link_state_t state_ff;
  pd_link_pkg::link_state_t nxt_state;
  logic [NM:0] seen_ff;
  logic [NM:0] nxt_seen;
  logic [NM:0] missing_ff;
  logic [NM:0] nxt_missing;
  logic [NM:0] expect_mask;
  logic [6:0]  alarm_node_ff;
  logic [6:0]  nxt_alarm_node;
  logic        alarm_ff;
  logic        nxt_alarm;
  logic        fault_ff;
  logic        nxt_fault;

  always_comb begin
    for (int unsigned n = 0; n <= NM; n++) begin
      expect_mask[n] = (n >= 1) && (n <= int'(cfg_nodes_ff)) &&
                       (7'(n) != cfg_addr_ff);
    end
    nxt_seen       = seen_ff;
    nxt_missing    = missing_ff;
    nxt_state      = state_ff;
    nxt_alarm      = alarm_ff;
    nxt_alarm_node = alarm_node_ff;
    nxt_fault      = fault_ff;
    if (fault_ack_in) begin
      nxt_fault = 1'b0;
    end
    if (rx_valid_in && rx_src_in <= 7'(NM)) begin
      nxt_seen[rx_src_in] = 1'b1;
    end
    case (state_ff)
      pd_link_pkg::LINK_OFF: begin
        if (cfg_en_ff) begin
          nxt_state = pd_link_pkg::LINK_BOOT;
        end
      end
      pd_link_pkg::LINK_BOOT, pd_link_pkg::LINK_CYCLIC: begin
        if (tick_ff) begin
          nxt_seen    = '0;
          nxt_missing = expect_mask & ~seen_ff;
          if ((nxt_missing & ~missing_ff) != '0 &&
              state_ff == pd_link_pkg::LINK_CYCLIC) begin
            nxt_fault = 1'b1;
          end
          if (nxt_missing == '0) begin
            nxt_alarm      = 1'b0;
            nxt_alarm_node = 7'h00;
            nxt_state      = pd_link_pkg::LINK_CYCLIC;
          end else begin
            nxt_alarm      = 1'b1;
            nxt_alarm_node = next_missing(nxt_missing,
                                          alarm_node_ff);
          end
        end
      end
      default: begin
        nxt_state = pd_link_pkg::LINK_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state_ff      <= pd_link_pkg::LINK_OFF;
      seen_ff       <= '0;
      missing_ff    <= '0;
      alarm_ff      <= 1'b0;
      alarm_node_ff <= 7'h00;
      fault_ff      <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      seen_ff       <= nxt_seen;
      missing_ff    <= nxt_missing;
      alarm_ff      <= nxt_alarm;
      alarm_node_ff <= nxt_alarm_node;
      fault_ff      <= nxt_fault;
    end
  end

  assign sender_missing_alarm_out   = alarm_ff;
  assign sender_missing_node_out    = alarm_node_ff;
  assign setpoint_timeout_fault_out = fault_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Status, interface assignment and identification

  logic        active_ff;
  logic        master_ff;
  logic [1:0]  if_one_ff;
  logic [1:0]  if_two_ff;
  logic [1:0]  nxt_if_one;
  logic [1:0]  nxt_if_two;
  logic [15:0] ident_ff;

  always_comb begin
    nxt_if_one = pd_link_pkg::IF_SRC_ONBOARD;
    nxt_if_two = opt_sync_ff ? pd_link_pkg::IF_SRC_COMM
                             : pd_link_pkg::IF_SRC_NONE;
    if (interface_hw_assignment_in == pd_link_pkg::HW_ASSIGN_AUTO) begin
      nxt_if_one = pd_link_pkg::IF_SRC_ONBOARD;
    end else if (interface_hw_assignment_in == pd_link_pkg::HW_ASSIGN_ONB) begin
      nxt_if_one = pd_link_pkg::IF_SRC_ONBOARD;
      nxt_if_two = opt_sync_ff ? pd_link_pkg::IF_SRC_COMM
                               : pd_link_pkg::IF_SRC_NONE;
    end else if (interface_hw_assignment_in == pd_link_pkg::HW_ASSIGN_COMM &&
                 opt_sync_ff) begin
      nxt_if_one = pd_link_pkg::IF_SRC_COMM;
      nxt_if_two = pd_link_pkg::IF_SRC_ONBOARD;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      active_ff <= 1'b0;
      master_ff <= 1'b0;
      if_one_ff <= pd_link_pkg::IF_SRC_NONE;
      if_two_ff <= pd_link_pkg::IF_SRC_NONE;
      ident_ff  <= 16'h0000;
    end else begin
      active_ff <= (state_ff == pd_link_pkg::LINK_CYCLIC);
      master_ff <= cfg_en_ff &&
                   (cfg_addr_ff == pd_link_pkg::NODE_SYNC_MST);
      if_one_ff <= nxt_if_one;
      if_two_ff <= nxt_if_two;
      ident_ff  <= opt_sync_ff ? pd_link_pkg::OPTION_IDENT
                               : 16'h0000;
    end
  end

  assign link_active_out          = active_ff;
  assign sync_master_out          = master_ff;
  assign bus_cycle_out            = tick_ff;
  assign cyclic_interface_one_out = if_one_ff;
  assign cyclic_interface_two_out = if_two_ff;
  assign option_slot_ident_out    = ident_ff;

endmodule : process_data_link_mapper

/* pd_link_pkg.sv */
package pd_link_pkg;

  // Link geometry
  localparam int unsigned TEL_WORDS       = 16;
  localparam int unsigned WORD_W          = 16;
  localparam int unsigned SLOT_W          = 5;
  localparam int unsigned NODE_W          = 7;
  localparam int unsigned MAX_NODES       = 64;
  localparam int unsigned MAX_NODES_SYNC  = 16;

  // Configuration codes
  localparam logic [3:0]  FW_SEL_LINK     = 4'h3;
  localparam logic [6:0]  NODE_OFF        = 7'h00;
  localparam logic [6:0]  NODE_SYNC_MST   = 7'h01;
  localparam int unsigned SYNC_BIT        = 0;
  localparam logic [7:0]  HW_ASSIGN_AUTO  = 8'h63;
  localparam logic [7:0]  HW_ASSIGN_ONB   = 8'h01;
  localparam logic [7:0]  HW_ASSIGN_COMM  = 8'h02;

  // Cyclic interface source codes
  localparam logic [1:0]  IF_SRC_NONE     = 2'h0;
  localparam logic [1:0]  IF_SRC_ONBOARD  = 2'h1;
  localparam logic [1:0]  IF_SRC_COMM     = 2'h2;

  // Identification value of the option module, arbitrary
  localparam logic [15:0] OPTION_IDENT    = 16'hA5C3;

  // Free-running bus cycle timing
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned BUS_CYCLE_US    = 500;
  localparam int unsigned BUS_CYCLE_CYC   = BUS_CYCLE_US * CLK_MHZ;

  typedef enum logic [1:0] {
    LINK_OFF    = 2'b00,
    LINK_BOOT   = 2'b01,
    LINK_CYCLIC = 2'b11
  } link_state_t;

endpackage : pd_link_pkg

/* pd_skid_buffer.sv */
module pd_skid_buffer #(
  parameter int unsigned WIDTH = 17
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);

  logic [WIDTH-1:0] mem_ff [2];
  logic [WIDTH-1:0] nxt_mem [2];
  logic             wr_ptr_ff;
  logic             nxt_wr_ptr;
  logic             rd_ptr_ff;
  logic             nxt_rd_ptr;
  logic [1:0]       count_ff;
  logic [1:0]       nxt_count;
  logic             push;
  logic             pop;

  always_comb begin
    push         = in_valid_in && (count_ff != 2'h2);
    pop          = (count_ff != 2'h0) && out_ready_in;
    nxt_mem      = mem_ff;
    nxt_wr_ptr   = wr_ptr_ff;
    nxt_rd_ptr   = rd_ptr_ff;
    nxt_count    = count_ff;
    if (push) begin
      nxt_mem[wr_ptr_ff] = in_data_in;
      nxt_wr_ptr         = ~wr_ptr_ff;
    end
    if (pop) begin
      nxt_rd_ptr = ~rd_ptr_ff;
    end
    if (push && !pop) begin
      nxt_count = count_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 2'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else begin
      mem_ff    <= nxt_mem;
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
    end
  end

  assign in_ready_out  = (count_ff != 2'h2);
  assign out_valid_out = (count_ff != 2'h0);
  assign out_data_out  = mem_ff[rd_ptr_ff];

endmodule : pd_skid_buffer

/* pd_link_peer.sv */
module pd_link_peer (
  // Clock and link timing
  input  wire logic        core_clk_in,
  input  wire logic        bus_cycle_in,
  // Scenario control
  input  wire logic [3:0]  node_en_in,
  input  wire logic        stall_in,
  // Words towards the device
  output logic             rx_valid_out,
  output logic [6:0]       rx_src_out,
  output logic [3:0]       rx_pos_out,
  output logic [15:0]      rx_data_out,
  // Words from the device
  input  wire logic        tx_valid_in,
  input  wire logic [15:0] tx_data_in,
  input  wire logic        tx_first_in,
  output logic             tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cap [16];
  int          n_cap = 0;
  int          step = 99;
  logic [6:0]  src;
  // Peers hold addresses 1 and 3 of one ascending line
  assign src = (step < 16) ? 7'h01 : 7'h03;
  initial begin
    rx_valid_out = 1'b0;
    rx_src_out = 7'h00;
    rx_pos_out = 4'h0;
    rx_data_out = 16'h0000;
    tx_ready_out = 1'b1;
  end
  // Frames follow the device's bus cycle
  always @(posedge core_clk_in) begin
    tx_ready_out <= stall_in ? ~tx_ready_out : 1'b1;
    if (tx_valid_in && tx_ready_out) begin
      cap[tx_first_in ? 4'h0 : n_cap[3:0]] <= tx_data_in;
      n_cap <= tx_first_in ? 1 : n_cap + 1;
    end
    step <= bus_cycle_in ? 0 : (step < 32 ? step + 1 : step);
    if (step < 32 && node_en_in[src[1:0]]) begin
      rx_valid_out <= 1'b1;
      rx_src_out <= src;
      rx_pos_out <= step[3:0];
      rx_data_out <= {4'h5, src[3:0], 4'h0, step[3:0]};
    end else begin
      // Released lines toggle between the last word and its complement
      rx_valid_out <= 1'b0;
      rx_src_out <= ~rx_src_out;
      rx_pos_out <= ~rx_pos_out;
      rx_data_out <= ~rx_data_out;
    end
  end
endmodule : pd_link_peer

/* process_data_link_mapper_monitor.sv */
module process_data_link_mapper_monitor #(
  parameter int unsigned BUS_CYCLE_CYCLES = 64
) (
  // Clock and reset
  input wire logic         core_clk_in,
  input wire logic         resetn_in,
  // Controls
  input wire logic [1:0]   link_sync_settings_in,
  input wire logic [7:0]   interface_hw_assignment_in,
  input wire logic         fault_ack_in,
  input wire logic         tx_ready_in,
  // Results
  input wire logic         tx_valid_out,
  input wire logic [15:0]  tx_data_out,
  input wire logic         tx_first_out,
  input wire logic [255:0] receive_word_array_out,
  input wire logic [479:0] receive_dword_array_out,
  input wire logic         bus_cycle_out,
  input wire logic         sender_missing_alarm_out,
  input wire logic [6:0]   sender_missing_node_out,
  input wire logic         setpoint_timeout_fault_out,
  input wire logic [1:0]   cyclic_interface_one_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  int unsigned  gap_ff, nxt_gap;
  logic         seen_ff, nxt_seen;
  logic [479:0] dw_exp;
  always_comb begin
    nxt_gap = bus_cycle_out ? '0 : gap_ff + 1;
    nxt_seen = seen_ff | bus_cycle_out;
    for (int s = 0; s < 15; s++) begin
      dw_exp[32*s +: 32] = {receive_word_array_out[16*s +: 16],
                            receive_word_array_out[16*s+16 +: 16]};
    end
  end
  always_ff @(posedge core_clk_in) begin
    gap_ff <= resetn_in ? nxt_gap : '0;
    seen_ff <= resetn_in & nxt_seen;
  end
  bus_pulse_a: assert property (bus_cycle_out |=> !bus_cycle_out)
    else $error("bus cycle pulse longer than one clock");
  bus_period_a: assert property (bus_cycle_out && seen_ff &&
    !link_sync_settings_in[0] |-> gap_ff == BUS_CYCLE_CYCLES - 1)
    else $error("free bus cycle period wrong");
  tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out) && $stable(tx_first_out))
    else $error("stalled telegram word not held");
  arrays_stable_a: assert property (!$past(bus_cycle_out) |->
    $stable(receive_word_array_out))
    else $error("receive words changed outside bus cycle");
  dword_pair_a: assert property (receive_dword_array_out == dw_exp)
    else $error("double word not built from word pair");
  alarm_stable_a: assert property (!$past(bus_cycle_out) |->
    $stable(sender_missing_node_out) && $stable(sender_missing_alarm_out))
    else $error("alarm changed outside bus cycle");
  alarm_node_a: assert property (sender_missing_alarm_out |->
    sender_missing_node_out != pd_link_pkg::NODE_OFF)
    else $error("alarm without node number");
  fault_hold_a: assert property (setpoint_timeout_fault_out &&
    !fault_ack_in |=> setpoint_timeout_fault_out)
    else $error("fault dropped without acknowledge");
  fault_cause_a: assert property ($rose(setpoint_timeout_fault_out) |->
    $past(bus_cycle_out) && sender_missing_alarm_out)
    else $error("fault raised without missing sender");
  iface_auto_a: assert property (interface_hw_assignment_in ==
    pd_link_pkg::HW_ASSIGN_AUTO |=>
    cyclic_interface_one_out == pd_link_pkg::IF_SRC_ONBOARD)
    else $error("automatic interface one not onboard");
endmodule : process_data_link_mapper_monitor

bind process_data_link_mapper process_data_link_mapper_monitor #(
  .BUS_CYCLE_CYCLES(BUS_CYCLE_CYCLES)
) i_process_data_link_mapper_monitor (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .link_sync_settings_in(link_sync_settings_in),
  .interface_hw_assignment_in(interface_hw_assignment_in),
  .fault_ack_in(fault_ack_in), .tx_ready_in(tx_ready_in),
  .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
  .tx_first_out(tx_first_out),
  .receive_word_array_out(receive_word_array_out),
  .receive_dword_array_out(receive_dword_array_out),
  .bus_cycle_out(bus_cycle_out),
  .sender_missing_alarm_out(sender_missing_alarm_out),
  .sender_missing_node_out(sender_missing_node_out),
  .setpoint_timeout_fault_out(setpoint_timeout_fault_out),
  .cyclic_interface_one_out(cyclic_interface_one_out));

/* tb_process_data_link_mapper.sv */
module tb_process_data_link_mapper;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CYC = 64;
  logic core_clk_in, resetn_in = 1'b0, opt = 1'b1, ack = 1'b0;
  logic stall = 1'b0, rx_valid, tx_valid, tx_first, tx_ready;
  logic active, smst, bcyc, alarm, fault;
  logic [3:0] fw_sel = 4'h3, en = 4'hA, rx_pos;
  logic [6:0] addr = 7'h02, rx_src, anode;
  logic [15:0] rx_data, tx_data, ident;
  logic [1:0] if1, if2;
  logic [255:0] srcw = '0, rwords;
  logic [79:0] slots = '0, ridx = '0;
  logic [111:0] rsrc = '0;
  logic [479:0] rdw;
  int num_errors = 0, n_tests = 0;

  process_data_link_mapper #(.BUS_CYCLE_CYCLES(CYC)) i_process_data_link_mapper (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .module_firmware_select_in(fw_sel), .link_node_address_in(addr),
    .link_sync_settings_in(2'h0), .link_max_node_count_in(7'h03),
    .interface_hw_assignment_in(pd_link_pkg::HW_ASSIGN_AUTO),
    .option_present_in(opt), .ctrl_cycle_in(1'b0),
    .send_word_source_in(srcw), .send_slot_table_in(slots),
    .receive_source_address_table_in(rsrc),
    .receive_word_index_table_in(ridx),
    .rx_valid_in(rx_valid), .rx_src_in(rx_src), .rx_pos_in(rx_pos),
    .rx_data_in(rx_data), .tx_valid_out(tx_valid), .tx_data_out(tx_data),
    .tx_first_out(tx_first), .tx_ready_in(tx_ready),
    .receive_word_array_out(rwords), .receive_dword_array_out(rdw),
    .link_active_out(active), .sync_master_out(smst),
    .bus_cycle_out(bcyc), .sender_missing_alarm_out(alarm),
    .sender_missing_node_out(anode), .setpoint_timeout_fault_out(fault),
    .fault_ack_in(ack), .cyclic_interface_one_out(if1),
    .cyclic_interface_two_out(if2), .option_slot_ident_out(ident));

  pd_link_peer i_pd_link_peer (
    .core_clk_in(core_clk_in), .bus_cycle_in(bcyc), .node_en_in(en),
    .stall_in(stall), .rx_valid_out(rx_valid), .rx_src_out(rx_src),
    .rx_pos_out(rx_pos), .rx_data_out(rx_data), .tx_valid_in(tx_valid),
    .tx_data_in(tx_data), .tx_first_in(tx_first), .tx_ready_out(tx_ready));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic do_reset(input logic [3:0] f, input logic [6:0] a);
    @(posedge core_clk_in);
    resetn_in <= 1'b0;
    fw_sel <= f;
    addr <= a;
    repeat (8) @(posedge core_clk_in);
    resetn_in <= 1'b1;
  endtask : do_reset

  // Waits for n bus cycle pulses
  task automatic wait_bus(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge core_clk_in);
        #1;
        k++;
      end while (bcyc !== 1'b1 && k < 3 * CYC);
      if (k >= 3 * CYC) begin
        num_errors++;
        print_verdict();
      end
    end
    repeat (3) @(posedge core_clk_in);
    #1;
  endtask : wait_bus

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_config();
    do_reset(4'h2, 7'h02);
    repeat (3 * CYC) @(posedge core_clk_in);
    #1;
    chk("active", 1'b0, active);
    @(posedge core_clk_in);
    fw_sel <= 4'h3;
    repeat (3 * CYC) @(posedge core_clk_in);
    #1;
    chk("active", 1'b0, active);
    do_reset(4'h3, 7'h01);
    wait_bus(3);
    chk("sync master", 1'b1, smst);
    chk("alarm node", 7'h02, anode);
    @(posedge core_clk_in);
    opt <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    #1;
    chk("ident", 16'h0000, ident);
    chk("if two", pd_link_pkg::IF_SRC_NONE, if2);
    @(posedge core_clk_in);
    opt <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    #1;
    chk("ident", pd_link_pkg::OPTION_IDENT, ident);
    chk("if one", pd_link_pkg::IF_SRC_ONBOARD, if1);
    chk("if two", pd_link_pkg::IF_SRC_COMM, if2);
    do_reset(4'h3, 7'h02);
    wait_bus(3);
    chk("active", 1'b1, active);
    chk("sync master", 1'b0, smst);
  endtask : t_config

  task automatic t_send();
    logic [79:0] v = '0;
    logic [255:0] sw;
    logic [4:0] e;
    int k = 0;
    for (int p = 0; p < 16; p++) sw[16*p +: 16] = 16'hC000 + 16'(p);
    v[4:0] = 5'h01;
    v[9:5] = 5'h02;
    v[14:10] = 5'h03;
    v[19:15] = 5'h10;
    v[79:75] = 5'h05;
    @(posedge core_clk_in);
    stall <= 1'b1;
    srcw <= sw;
    slots <= v;
    wait_bus(2);
    while (i_pd_link_peer.n_cap != 16 && k < 2 * CYC) begin
      @(posedge core_clk_in);
      k++;
    end
    if (k >= 2 * CYC) num_errors++;
    for (int p = 0; p < 16; p++) begin
      e = v[5*p +: 5];
      chk("tx word", e == 5'h00 ? 16'h0000 : sw[16*(e-1) +: 16],
          i_pd_link_peer.cap[p]);
    end
    @(posedge core_clk_in);
    stall <= 1'b0;
  endtask : t_send

  task automatic t_receive();
    logic [111:0] s = '0;
    logic [79:0] x = '0;
    logic [6:0] a;
    logic [4:0] w;
    logic [15:0] ew [16];
    s[0 +: 7] = 7'h01;
    x[0 +: 5] = 5'h01;
    s[7 +: 7] = 7'h03;
    x[5 +: 5] = 5'h10;
    s[14 +: 7] = 7'h01;
    x[10 +: 5] = 5'h05;
    s[21 +: 7] = 7'h01;
    x[15 +: 5] = 5'h06;
    s[28 +: 7] = 7'h02;
    x[20 +: 5] = 5'h01;
    x[25 +: 5] = 5'h03;
    s[42 +: 7] = 7'h03;
    s[49 +: 7] = 7'h05;
    x[35 +: 5] = 5'h02;
    @(posedge core_clk_in);
    rsrc <= s;
    ridx <= x;
    wait_bus(3);
    for (int k = 0; k < 16; k++) begin
      a = s[7*k +: 7];
      w = x[5*k +: 5];
      ew[k] = (a == 7'h00 || w == 5'h00 || a == 7'h02 || a > 7'h03) ?
              16'h0000 : {4'h5, a[3:0], 4'h0, 4'(w - 5'h01)};
      chk("rx word", ew[k], rwords[16*k +: 16]);
    end
    chk("rx dword", {ew[2], ew[3]}, rdw[64 +: 32]);
  endtask : t_receive

  task automatic t_missing();
    logic [7:0] seen = '0;
    @(posedge core_clk_in);
    en <= 4'b0010;
    wait_bus(3);
    chk("alarm", 1'b1, alarm);
    chk("alarm node", 7'h03, anode);
    chk("fault", 1'b1, fault);
    @(posedge core_clk_in);
    ack <= 1'b1;
    @(posedge core_clk_in);
    ack <= 1'b0;
    #1;
    chk("fault", 1'b0, fault);
    @(posedge core_clk_in);
    en <= 4'b1010;
    wait_bus(3);
    chk("alarm", 1'b0, alarm);
    @(posedge core_clk_in);
    en <= 4'b0000;
    wait_bus(2);
    for (int i = 0; i < 4; i++) begin
      if (alarm === 1'b1) seen[anode[2:0]] = 1'b1;
      wait_bus(1);
    end
    chk("nodes seen", 8'h0A, seen);
  endtask : t_missing

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  initial begin
    t_config();
    t_send();
    t_receive();
    t_missing();
    print_verdict();
  end
endmodule : tb_process_data_link_mapper
